// *** logic/cap_regs.sv ***
/*
 * Agent control register, the two orb pointer views and the unsolicited
 * status enable flags of four command block agents, behind an apb slave.
 * Assumes bus_reset, tx_tag, orb_upd, agent_reset and unsol_en_write come
 * from link logic on the same clock; no synchroniser is used for them.
 */
`include "cap_map.svh"

module cap_regs #(
    parameter int AGENTS = 4
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire cap_pkg::cap_apb_req_type    apb_req,
    output cap_pkg::cap_apb_rsp_type         apb_rsp,
    input  wire logic                        bus_reset,
    input  wire cap_pkg::cap_tx_tag_type     tx_tag,
    input  wire cap_pkg::cap_orb_upd_type    orb_upd,
    input  wire logic [AGENTS-1:0]           agent_reset,
    input  wire logic [AGENTS-1:0]           unsol_en_write,
    output logic      [AGENTS-1:0]           unsol_status_enable_flags,
    output logic                             agent_id_valid,
    output logic      [1:0]                  agent_select
);
    import cap_pkg::*;

    cap_state_type     state_q;
    cap_state_type     state_d;
    logic              autoclear_q;
    logic              autoclear_d;
    logic              valid_d;
    logic        [1:0] select_d;
    logic        [15:0] bus_id_q;
    logic        [15:0] bus_id_d;
    logic        [AGENTS-1:0] unsol_d;
    cap_apb_rsp_type   rsp_d;
    logic              id_we;
    logic        [15:0] mem_id;
    cap_orb_type       mem_orb;

    // field placement helper, used for the read image only; the write decode slices pwdata directly
    function automatic logic [31:0] control_image(input logic [1:0]  sel,
                                                  input logic        acl,
                                                  input logic        vld,
                                                  input logic [15:0] id);
        logic [31:0] img;
        img = 32'h00000000;
        img[`CAP_POS_AGENT_SELECT +: 2] = sel;
        img[`CAP_POS_AUTOCLEAR_EN]      = acl;
        img[`CAP_POS_ID_VALID]          = vld;
        img[`CAP_POS_BUS_ID +: 16]      = id;   // R16
        return img;
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // the memory sees the next select and id, so a strobe acts on the agent
    // and id carried by the same write, not on the ones stored before it
    cap_agent_mem #(
        .AGENTS      (AGENTS)
    ) u_mem (
        .clock       (clock),
        .nrst        (nrst),
        .sel         (select_d),
        .id_we       (id_we),
        .id_wdata    (bus_id_d),
        .orb_upd     (orb_upd),
        .agent_reset (agent_reset),
        .id_rdata    (mem_id),
        .orb_rdata   (mem_orb)
    );

    // the access phase waits one cycle so the selected agent's memory
    // output is registered before it is sampled; costs one wait state
    always_comb begin
        state_d     = state_q;
        autoclear_d = autoclear_q;
        valid_d     = agent_id_valid;
        select_d    = agent_select;
        bus_id_d    = bus_id_q;
        id_we       = 1'b0;
        rsp_d       = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};
        case (state_q)
            CAP_IDLE: begin
                if (apb_req.psel && !apb_req.penable) begin
                    state_d = CAP_ACCESS;
                end
            end
            CAP_ACCESS: begin
                state_d = CAP_IDLE;
                rsp_d.pready = 1'b1;
                if (is_addr(apb_req.paddr, `CAP_OFS_AGENT_CONTROL)) begin
                    if (apb_req.pwrite) begin
                        select_d    = apb_req.pwdata[`CAP_POS_AGENT_SELECT +: 2];
                        autoclear_d = apb_req.pwdata[`CAP_POS_AUTOCLEAR_EN];
                        bus_id_d    = apb_req.pwdata[`CAP_POS_BUS_ID +: 16];
                        if (apb_req.pwdata[`CAP_POS_ID_VALID]) begin
                            valid_d = 1'b1; // R5
                        end
                        if (apb_req.pwdata[`CAP_POS_ID_WRITE]) begin
                            // strobe is never stored, so it reads back 0
                            id_we = 1'b1; // R7
                        end
                        if (apb_req.pwdata[`CAP_POS_ID_READ]) begin
                            // hold off pready until the new select settles
                            rsp_d.pready = 1'b0;
                            state_d      = CAP_ID_FETCH; // R8
                        end
                    end else begin
                        rsp_d.prdata = control_image(agent_select, autoclear_q,
                                                     agent_id_valid, bus_id_q);
                    end
                end else if (is_addr(apb_req.paddr, `CAP_OFS_ORB_HIGH_VIEW)) begin
                    rsp_d.prdata = {16'h0000, mem_orb.high}; // R12
                    rsp_d.pslverr = apb_req.pwrite;
                end else if (is_addr(apb_req.paddr, `CAP_OFS_ORB_LOW_VIEW)) begin
                    rsp_d.prdata = mem_orb.low; // R13
                    rsp_d.pslverr = apb_req.pwrite;
                end else if (is_addr(apb_req.paddr, `CAP_OFS_UNSOL_STATUS)) begin
                    rsp_d.prdata = {{(32-AGENTS){1'b0}}, unsol_status_enable_flags};
                    rsp_d.pslverr = apb_req.pwrite;
                end else begin
                    rsp_d.pslverr = 1'b1;
                end
            end
            CAP_ID_FETCH: begin
                // the memory read is registered; this cycle it shows the new agent
                bus_id_d     = mem_id; // R8
                rsp_d.pready = 1'b1;
                state_d      = CAP_IDLE;
            end
            default: begin
                state_d = CAP_IDLE;
            end
        endcase
        if (bus_reset) begin
            valid_d = 1'b0; // R6 R11
        end
    end

    // set wins over clear so a bus write racing a transmit is not lost
    always_comb begin
        unsol_d = unsol_status_enable_flags;
        if (tx_tag.valid && autoclear_q &&
            tx_tag.tlabel[5:3] == `CAP_TAG_UNSOL_PREFIX &&
            tx_tag.tlabel[2:1] == agent_select) begin
            unsol_d = '0; // R3
        end // R4
        unsol_d = unsol_d | unsol_en_write; // R15
        if (bus_reset) begin
            unsol_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q                   <= CAP_IDLE;
            autoclear_q               <= 1'b0;
            agent_id_valid            <= 1'b0; // R6
            agent_select              <= 2'h0;
            bus_id_q                  <= `CAP_RST_BUS_ID; // R9 R11
            unsol_status_enable_flags <= '0;
            apb_rsp                   <= '{pready: 1'b0, pslverr: 1'b0,
                                           prdata: 32'h00000000};
        end else begin
            state_q                   <= state_d;
            autoclear_q               <= autoclear_d;
            agent_id_valid            <= valid_d;
            agent_select              <= select_d;
            bus_id_q                  <= bus_id_d;
            unsol_status_enable_flags <= unsol_d;
            apb_rsp                   <= rsp_d;
        end
    end

endmodule

// *** inc/cap_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * command agent id / orb pointer register bank.
 * Assumes an APB slave with 32-bit data; offsets are byte addresses.
 */
// Overview of operation
// R1: agent_select picks which agent's orb pointer shows in both pointer views.
// R2: agent_select also picks the agent for id write and id read strobes.
// R3: autoclear enabled and tag 111b+agent+x sent: clear all four unsolicited enables.
// R4: autoclear disabled: such a transmitted tag leaves unsolicited enables unchanged.
// R5: writing agent_id_valid 1 marks the selected agent's node id valid.
// R6: agent_id_valid resets to 0 and every bus reset forces it to 0.
// R7: id write strobe loads the id field into the selected agent, then self-clears.
// R8: id read strobe returns the selected agent's id in the field, then clears.
// R9: id field is low halfword, resets to ffff, survives bus resets.
// R10: host rewrites each active agent's id after every bus reset.
// R11: agent control resets to 0000ffff; bus reset clears only the valid bit.
// R12: high pointer view: low 16 bits orb_ptr_high, upper zero, default 0.
// R13: low pointer view: all 32 bits orb_ptr_low, default 0, bus reset safe.
// R14: an agent reset by its initiator returns that agent's orb pointer to zero.
// R15: a bus write to an agent's unsolicited enable register sets its flag.
// R16: bit 0 is the msb, so bits 16 to 31 are the low halfword.
`ifndef CAP_MAP_SVH
`define CAP_MAP_SVH

`define CAP_OFS_AGENT_CONTROL   8'h50
`define CAP_OFS_ORB_HIGH_VIEW   8'h54
`define CAP_OFS_ORB_LOW_VIEW    8'h58
`define CAP_OFS_UNSOL_STATUS    8'h60

`define CAP_RST_AGENT_CONTROL   32'h0000ffff
`define CAP_RST_BUS_ID          16'hffff
`define CAP_RST_ORB_HIGH        16'h0000
`define CAP_RST_ORB_LOW         32'h00000000

// little-endian positions of msb-numbered fields
`define CAP_POS_AGENT_SELECT    30
`define CAP_POS_AUTOCLEAR_EN    20
`define CAP_POS_ID_VALID        19
`define CAP_POS_ID_WRITE        17
`define CAP_POS_ID_READ         16
`define CAP_POS_BUS_ID          0

`define CAP_TAG_UNSOL_PREFIX    3'h7
`define CAP_RESP_LATENCY        1

`endif

// *** inc/cap_pkg.sv ***
/*
 * Types shared by the register bank and its agent memory.
 * Assumes cap_map.svh is on the include path.
 */
package cap_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cap_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cap_apb_rsp_type;

    // first quadlet handed to the transmitter by the host
    typedef struct packed {
        logic       valid;
        logic [5:0] tlabel;
    } cap_tx_tag_type;

    // orb pointer update from the bus side
    typedef struct packed {
        logic        valid;
        logic [1:0]  agent;
        logic [15:0] high;
        logic [31:0] low;
    } cap_orb_upd_type;

    typedef struct packed {
        logic [15:0] high;
        logic [31:0] low;
    } cap_orb_type;

    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_ACCESS,
        CAP_ID_FETCH
    } cap_state_type;

endpackage

// *** logic/cap_agent_mem.sv ***
/*
 * Per-agent store: bus node id and orb pointer of each command block agent.
 * Read data come out of registers, one cycle after the select.
 * Assumes a single clock and synchronous active-low reset.
 */
`include "cap_map.svh"

module cap_agent_mem #(
    parameter int AGENTS = 4
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic [$clog2(AGENTS)-1:0]   sel,
    input  wire logic                        id_we,
    input  wire logic [15:0]                 id_wdata,
    input  wire cap_pkg::cap_orb_upd_type    orb_upd,
    input  wire logic [AGENTS-1:0]           agent_reset,
    output logic      [15:0]                 id_rdata,
    output cap_pkg::cap_orb_type             orb_rdata
);
    import cap_pkg::*;

    logic        [15:0] id_q    [AGENTS];
    logic        [15:0] id_d    [AGENTS];
    cap_orb_type        orb_q   [AGENTS];
    cap_orb_type        orb_d   [AGENTS];
    logic        [15:0] id_rd_d;
    cap_orb_type        orb_rd_d;

    always_comb begin
        for (int i = 0; i < AGENTS; i++) begin
            id_d[i]  = id_q[i];
            orb_d[i] = orb_q[i];
            if (id_we && sel == i[$clog2(AGENTS)-1:0]) begin
                id_d[i] = id_wdata; // R7
            end
            if (orb_upd.valid && orb_upd.agent == i[$clog2(AGENTS)-1:0]) begin
                orb_d[i] = '{high: orb_upd.high, low: orb_upd.low};
            end
            // an initiator reset outranks a pointer update in the same cycle
            if (agent_reset[i]) begin
                orb_d[i] = '{high: `CAP_RST_ORB_HIGH, low: `CAP_RST_ORB_LOW}; // R14
            end
        end
        id_rd_d  = id_q[sel];  // R2
        orb_rd_d = orb_q[sel]; // R1
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < AGENTS; i++) begin
                id_q[i]  <= `CAP_RST_BUS_ID;
                orb_q[i] <= '{high: `CAP_RST_ORB_HIGH, low: `CAP_RST_ORB_LOW};
            end
            id_rdata  <= `CAP_RST_BUS_ID;
            orb_rdata <= '{high: `CAP_RST_ORB_HIGH, low: `CAP_RST_ORB_LOW};
        end else begin
            for (int i = 0; i < AGENTS; i++) begin
                id_q[i]  <= id_d[i];
                orb_q[i] <= orb_d[i];
            end
            id_rdata  <= id_rd_d;
            orb_rdata <= orb_rd_d;
        end
    end

endmodule

// *** tb/cap_regs_chk.sv ***
/* checker of the agent control / orb pointer bank, bound to cap_regs.
   assumes one clock and a synchronous active-low reset. */
`include "cap_map.svh"

module cap_regs_chk #(
    parameter int AGENTS = 4
) (
    input wire logic                     clock,
    input wire logic                     nrst,
    input wire cap_pkg::cap_apb_req_type apb_req,
    input wire cap_pkg::cap_apb_rsp_type apb_rsp,
    input wire logic                     bus_reset,
    input wire cap_pkg::cap_tx_tag_type  tx_tag,
    input wire cap_pkg::cap_orb_upd_type orb_upd,
    input wire logic [AGENTS-1:0]        agent_reset,
    input wire logic [AGENTS-1:0]        unsol_en_write,
    input wire logic [AGENTS-1:0]        unsol_status_enable_flags,
    input wire logic                     agent_id_valid,
    input wire logic [1:0]               agent_select
);
    timeunit 1ns;
    timeprecision 1ps;
    import cap_pkg::*;
    logic acl_q;
    logic acl_d;
    logic wr_ctl;
    // autoclear is not a port, so it is shadowed from completed writes
    assign wr_ctl = apb_req.psel && apb_req.pwrite && apb_rsp.pready
                    && apb_req.paddr == `CAP_OFS_AGENT_CONTROL;
    always_comb begin
        acl_d = wr_ctl ? apb_req.pwdata[`CAP_POS_AUTOCLEAR_EN] : acl_q;
    end
    always_ff @(posedge clock) begin
        acl_q <= nrst ? acl_d : 1'b0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_answer;
        apb_rsp.pready;
    endsequence
    chk_answer_bound: assert property (s_setup |-> ##[2:3] s_answer)
        else $error("answer late");
    chk_sel_write: assert property (wr_ctl |=> agent_select == $past(apb_req.pwdata[31:30]))
        else $error("select not written");
    chk_valid_set: assert property (wr_ctl && apb_req.pwdata[`CAP_POS_ID_VALID]
        && !bus_reset && !$past(bus_reset) && !$past(bus_reset, 2) |=> agent_id_valid)
        else $error("valid not set");
    chk_valid_busrst: assert property (bus_reset |=> !agent_id_valid)
        else $error("valid kept over bus reset");
    chk_flag_set: assert property (unsol_en_write != '0 && !bus_reset |=>
        (unsol_status_enable_flags & $past(unsol_en_write)) == $past(unsol_en_write))
        else $error("unsolicited flag not set");
    chk_autoclr_on: assert property (tx_tag.valid && acl_q && unsol_en_write == '0
        && tx_tag.tlabel[5:1] == {3'b111, agent_select} && !bus_reset
        |=> unsol_status_enable_flags == '0) else $error("flags not cleared");
    chk_autoclr_off: assert property (!(tx_tag.valid && acl_q) && unsol_en_write == '0
        && !bus_reset |=> $stable(unsol_status_enable_flags)) else $error("flags changed");
    chk_ro_write: assert property (s_answer and apb_req.pwrite && apb_req.paddr inside
        {`CAP_OFS_ORB_HIGH_VIEW, `CAP_OFS_ORB_LOW_VIEW} |-> apb_rsp.pslverr)
        else $error("pointer view write accepted");
    chk_high_upper: assert property (s_answer and !apb_req.pwrite
        && apb_req.paddr == `CAP_OFS_ORB_HIGH_VIEW |-> apb_rsp.prdata[31:16] == 16'h0)
        else $error("high view upper bits set");
endmodule

bind cap_regs cap_regs_chk #(.AGENTS(AGENTS)) u_chk (.clock, .nrst, .apb_req, .apb_rsp,
    .bus_reset, .tx_tag, .orb_upd, .agent_reset, .unsol_en_write, .unsol_status_enable_flags,
    .agent_id_valid, .agent_select);

// *** tb/cap_far_model.sv ***
/* serial bus side: remote initiators writing pointers, resetting agents.
   assumes the bench calls its tasks; orb_upd goes to inverse values when idle, the other lines to 0. */
module cap_far_model (
    input  wire logic                clock,
    output cap_pkg::cap_orb_upd_type orb_upd,
    output logic [3:0]               agent_reset,
    output logic [3:0]               unsol_en_write,
    output logic                     bus_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import cap_pkg::*;
    initial begin
        orb_upd = '0;
        agent_reset = '0;
        unsol_en_write = '0;
        bus_reset = 1'b0;
    end
    task automatic write_orb(input logic [1:0] a, input logic [15:0] h, input logic [31:0] l);
        @(posedge clock) orb_upd <= '{1'b1, a, h, l};
        @(posedge clock) orb_upd <= '{1'b0, ~a, ~h, ~l};
    endtask
    task automatic reset_agent(input logic [1:0] a);
        @(posedge clock) agent_reset <= 4'h1 << a;
        @(posedge clock) agent_reset <= '0;
    endtask
    task automatic unsol_write(input logic [3:0] m);
        @(posedge clock) unsol_en_write <= m;
        @(posedge clock) unsol_en_write <= '0;
    endtask
    task automatic bus_rst();
        @(posedge clock) bus_reset <= 1'b1;
        @(posedge clock) bus_reset <= 1'b0;
    endtask
endmodule

// *** tb/cap_regs_tb.sv ***
/* self-checking bench of cap_regs with an apb master and the far-side model.
   assumes cap_pkg compiled first and cap_map.svh on the include path. */
module cap_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cap_pkg::*;
    logic            clock = 1'b0;
    logic            nrst = 1'b0;
    logic            bus_reset;
    logic            valid;
    logic            err;
    logic [1:0]      sel;
    logic [3:0]      agent_reset, unsol_en_write, flags;
    logic [31:0]     lfsr = 32'h0c6c, rd;
    logic [15:0]     idm [4], ohm [4];
    logic [31:0]     olm [4];
    cap_apb_req_type req = '0;
    cap_apb_rsp_type rsp;
    cap_tx_tag_type  tag = '0;
    cap_orb_upd_type upd;
    int              failures = 0, n_tests = 0;
    always #2 clock = ~clock;
    cap_regs #(.AGENTS(4)) dut (.clock, .nrst, .apb_req(req), .apb_rsp(rsp), .bus_reset,
        .tx_tag(tag), .orb_upd(upd), .agent_reset, .unsol_en_write,
        .unsol_status_enable_flags(flags), .agent_id_valid(valid), .agent_select(sel));
    cap_far_model far (.clock, .orb_upd(upd), .agent_reset, .unsol_en_write, .bus_reset);
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [31:0] ctl(input logic [1:0] a, input logic [15:0] id);
        return {a, 14'h0, id};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock) req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock) req.penable <= 1'b1;
        i = 0;
        // pready is read at the rising edge, before the design updates it
        do begin
            @(posedge clock);
            i++;
        end while (rsp.pready !== 1'b1 && i < 20);
        if (rsp.pready !== 1'b1) begin
            failures++;
            stop_test();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        // released lines carry inverted values so nothing relies on stale data
        req <= '{1'b0, 1'b0, ~w, ~a, ~d};
        @(negedge clock);
    endtask
    task automatic tx(input logic [5:0] t);
        @(posedge clock) tag <= '{1'b1, t};
        @(posedge clock) tag <= '{1'b0, ~t};
        @(negedge clock);
    endtask
    initial begin
        int a;
        logic [31:0] h;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        apb(0, 8'h50, 0);
        check("control", rd, 32'h0000ffff);
        check("valid", valid, 0);
        apb(0, 8'h54, 0);
        check("ptr_high", rd, 0);
        apb(0, 8'h58, 0);
        check("ptr_low", rd, 0);
        for (a = 0; a < 4; a++) begin
            h = rnd();
            idm[a] = h[15:0];
            ohm[a] = h[31:16];
            olm[a] = rnd();
            far.write_orb(a[1:0], ohm[a], olm[a]);
            apb(1, 8'h50, {a[1:0], 12'h0, 2'b10, idm[a]});
        end
        for (a = 3; a >= 0; a--) begin
            apb(1, 8'h50, {a[1:0], 12'h0, 2'b01, ~idm[a]});
            apb(0, 8'h50, 0);
            check("id_field", rd & 32'hc003ffff, ctl(a[1:0], idm[a]));
            apb(0, 8'h54, 0);
            check("ptr_high", rd, {16'h0, ohm[a]});
            apb(0, 8'h58, 0);
            check("ptr_low", rd, olm[a]);
        end
        far.reset_agent(2'd0);
        apb(0, 8'h58, 0);
        check("ptr_agent_reset", rd, 0);
        far.unsol_write(4'hf);
        @(negedge clock);
        check("unsol_set", flags, 4'hf);
        apb(0, 8'h60, 0);
        check("unsol_view", rd, 32'h0000000f);
        apb(1, 8'h50, {2'd1, 30'h0});
        tx(6'b111011);
        check("unsol_off", flags, 4'hf);
        apb(1, 8'h50, {2'd1, 9'h0, 1'b1, 20'h0});
        tx(6'b111101);
        check("unsol_other", flags, 4'hf);
        tx(6'b111010);
        check("unsol_clear", flags, 0);
        apb(1, 8'h50, {2'd3, 10'h0, 1'b1, 3'b0, 16'h1234});
        check("valid_set", valid, 1);
        far.bus_rst();
        @(negedge clock);
        check("valid_busrst", valid, 0);
        check("select_kept", sel, 2'd3);
        apb(0, 8'h50, 0);
        check("id_keep", rd & 32'h0000ffff, 16'h1234);
        // a fresh id, so a lost write strobe cannot read back the old one
        apb(1, 8'h50, {2'd3, 12'h0, 2'b10, ~idm[3]});
        apb(1, 8'h50, {2'd3, 12'h0, 2'b01, 16'h0});
        apb(0, 8'h50, 0);
        check("id_kept", rd[15:0], 16'(~idm[3]));
        apb(1, 8'h58, rnd());
        check("ro_err", err, 1);
        apb(0, 8'h7c, 0);
        check("unmapped", err, 1);
        apb(0, 8'h58, 0);
        check("ro_kept", rd, olm[3]);
        stop_test();
    end
endmodule
